// ### tisc_ctrl.sv
// Mode, teach-in and indication controller of a transponder safety switch.
// Assumes the code reader and nonvolatile code store sit outside and present
// their results as synchronous levels; rst is the power-up or hardware restart.
`timescale 1ns/1ps
`include "tisc_regs.svh"

module tisc_ctrl #(
    parameter int TICK_CYCLES = `TISC_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Actuator reader and code store
    input  wire logic       tag_in_range,
    input  wire logic       tag_code_active,
    input  wire logic       tag_code_blocked,
    input  wire logic [3:0] taught_count,
    input  wire logic       fault_cond,
    output logic            teach_commit,
    // Safety outputs
    output logic            safety_output_a,
    output logic            safety_output_b,
    // Indicators
    output logic            led_green,
    output logic            led_yellow,
    output logic            led_red
);

    // A ratio of one ticks every cycle; simulation uses it to keep runs short.
    if (TICK_CYCLES < 1) $error("TICK_CYCLES must be at least 1");

    // ------------------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------------------
    logic [31:0] div_reg, div_next;
    logic        tick;
    assign tick = (div_reg == 32'(TICK_CYCLES - 1));

    always_comb begin
        div_next = tick ? 32'h0 : div_reg + 32'h1;
    end

    // ------------------------------------------------------------------------
    // Mode state
    // ------------------------------------------------------------------------
    tisc_pkg::tisc_state_t st_reg, st_next;
    logic [15:0] tmr_reg, tmr_next;
    logic [15:0] dwl_reg, dwl_next;
    logic [15:0] clr_reg, clr_next;
    logic        clr_ph_reg, clr_ph_next;
    logic [1:0]  fl_reg, fl_next;
    logic        boot_reg, boot_next;
    logic        in_d_reg;
    logic        commit_next, out_next, grn_next, yel_next, red_next;
    logic        short_dwell, rejoin;

    function automatic logic [1:0] status_flashes(input logic [3:0] n);
        if (n >= `TISC_TEACH_MAX) status_flashes = 2'd0;
        else if (n == 4'd7)       status_flashes = 2'd1;
        else if (n == 4'd6)       status_flashes = 2'd2;
        else                      status_flashes = 2'd3;
    endfunction

    // A dwell shorter than 0.5 s looks like a manipulation attempt.
    assign short_dwell = in_d_reg && !tag_in_range && (dwl_reg < `TISC_DWELL_MS);
    assign rejoin = clr_ph_reg && tag_in_range && tick && (clr_reg == `TISC_CLEAR_MS - 16'd1);

    always_comb begin
        st_next     = st_reg;
        tmr_next    = tmr_reg;
        fl_next     = fl_reg;
        boot_next   = 1'b0;
        commit_next = 1'b0;
        dwl_next    = !tag_in_range ? 16'h0 :
                      (tick && dwl_reg < `TISC_DWELL_MS) ? dwl_reg + 16'h1 : dwl_reg;
        clr_next    = clr_reg;
        clr_ph_next = clr_ph_reg;
        if (tick && tmr_reg != 16'hffff) tmr_next = tmr_reg + 16'h1;
        unique case (st_reg)
            tisc_pkg::TISC_ST_STATUS: begin
                // The count is sampled one cycle after reset release.
                if (boot_reg) begin
                    tmr_next = 16'h0;
                    fl_next  = status_flashes(taught_count);
                    if (taught_count == 4'h0) st_next = tisc_pkg::TISC_ST_READY;
                end else if (fl_reg == 2'd0) begin
                    st_next = tisc_pkg::TISC_ST_NORMAL;
                end else if (tick && tmr_reg == `TISC_FAST_PER_MS - 16'd1) begin
                    tmr_next = 16'h0;
                    fl_next  = fl_reg - 2'd1;
                end
            end
            tisc_pkg::TISC_ST_READY, tisc_pkg::TISC_ST_NORMAL: begin
                if (tick && tmr_reg == `TISC_FAST_PER_MS - 16'd1) tmr_next = 16'h0;
                if (fault_cond || short_dwell) begin
                    st_next = tisc_pkg::TISC_ST_FAULT;
                end else if (tag_in_range && !in_d_reg && !tag_code_active) begin
                    tmr_next = 16'h0;
                    if (taught_count >= `TISC_TEACH_MAX) begin
                        st_next = tisc_pkg::TISC_ST_OPERR;
                        fl_next = `TISC_FLASH_REPEAT;
                    end else if (tag_code_blocked) begin
                        st_next = tisc_pkg::TISC_ST_OPERR;
                        fl_next = `TISC_FLASH_OLD;
                    end else begin
                        st_next = tisc_pkg::TISC_ST_TEACH;
                    end
                end
            end
            tisc_pkg::TISC_ST_TEACH: begin
                if (fault_cond) begin
                    st_next = tisc_pkg::TISC_ST_FAULT;
                end else if (!tag_in_range) begin
                    st_next  = tisc_pkg::TISC_ST_OPERR;
                    fl_next  = `TISC_FLASH_ABORT;
                    tmr_next = 16'h0;
                end else if (tick && tmr_reg == `TISC_TEACH_MS - 16'd1) begin
                    st_next     = tisc_pkg::TISC_ST_TAUGHT;
                    commit_next = 1'b1;
                end
            end
            tisc_pkg::TISC_ST_TAUGHT: begin
                // Held until a restart activates the newly stored code.
                st_next = tisc_pkg::TISC_ST_TAUGHT;
            end
            tisc_pkg::TISC_ST_OPERR, tisc_pkg::TISC_ST_FAULT: begin
                if (fl_reg != 2'd0 && tick && tmr_reg == `TISC_FAST_PER_MS - 16'd1) begin
                    tmr_next = 16'h0;
                    fl_next  = fl_reg - 2'd1;
                end
                if (fault_cond) begin
                    st_next = tisc_pkg::TISC_ST_FAULT;
                end else if (rejoin) begin
                    st_next = (taught_count == 4'h0) ? tisc_pkg::TISC_ST_READY
                                                     : tisc_pkg::TISC_ST_NORMAL;
                    fl_next = 2'd0;
                end
            end
            default: st_next = tisc_pkg::TISC_ST_FAULT;
        endcase
        // Open for 2 s arms the clear, closed for 2 s releases it; a longer open stays armed.
        if (st_reg != tisc_pkg::TISC_ST_OPERR && st_reg != tisc_pkg::TISC_ST_FAULT) begin
            clr_next    = 16'h0;
            clr_ph_next = 1'b0;
        end else if (clr_ph_reg != tag_in_range) begin
            clr_next = 16'h0;
            if (clr_ph_reg && !tag_in_range && in_d_reg) clr_ph_next = 1'b0;
        end else if (tick) begin
            if (!clr_ph_reg && clr_reg == `TISC_CLEAR_MS - 16'd1) begin
                clr_ph_next = 1'b1;
                clr_next    = 16'h0;
            end else if (clr_reg < `TISC_CLEAR_MS) begin
                clr_next = clr_reg + 16'h1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Indication and outputs
    // ------------------------------------------------------------------------
    always_comb begin
        out_next = 1'b0;
        yel_next = 1'b0;
        red_next = 1'b0;
        grn_next = 1'b0;
        unique case (st_next)
            tisc_pkg::TISC_ST_NORMAL: begin
                grn_next = 1'b1;
                out_next = tag_in_range && tag_code_active;
                yel_next = out_next;
            end
            tisc_pkg::TISC_ST_READY:  grn_next = tmr_next < `TISC_FAST_HALF_MS;
            tisc_pkg::TISC_ST_TEACH:  grn_next = (tmr_next % `TISC_SLOW_PER_MS)
                                                 < `TISC_SLOW_HALF_MS;
            tisc_pkg::TISC_ST_STATUS: grn_next = fl_next != 2'd0
                                                 && tmr_next < `TISC_FAST_HALF_MS;
            tisc_pkg::TISC_ST_OPERR, tisc_pkg::TISC_ST_FAULT: begin
                red_next = 1'b1;
                grn_next = fl_next != 2'd0 && tmr_next < `TISC_FAST_HALF_MS;
            end
            default: grn_next = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            div_reg         <= 32'h0;
            st_reg          <= tisc_pkg::TISC_ST_STATUS;
            tmr_reg         <= 16'h0;
            dwl_reg         <= 16'h0;
            clr_reg         <= 16'h0;
            clr_ph_reg      <= 1'b0;
            fl_reg          <= 2'd0;
            boot_reg        <= 1'b1;
            in_d_reg        <= 1'b0;
            teach_commit    <= 1'b0;
            safety_output_a <= 1'b0;
            safety_output_b <= 1'b0;
            led_green       <= 1'b0;
            led_yellow      <= 1'b0;
            led_red         <= 1'b0;
        end else begin
            div_reg         <= div_next;
            st_reg          <= st_next;
            tmr_reg         <= tmr_next;
            dwl_reg         <= dwl_next;
            clr_reg         <= clr_next;
            clr_ph_reg      <= clr_ph_next;
            fl_reg          <= fl_next;
            boot_reg        <= boot_next;
            in_d_reg        <= tag_in_range;
            teach_commit    <= commit_next;
            safety_output_a <= out_next;
            safety_output_b <= out_next;
            led_green       <= grn_next;
            led_yellow      <= yel_next;
            led_red         <= red_next;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_teach_end;
        st_reg == tisc_pkg::TISC_ST_TEACH && tag_in_range && !fault_cond && tick
            && tmr_reg == `TISC_TEACH_MS - 16'd1;
    endsequence

    property p_closed_on;
        st_reg == tisc_pkg::TISC_ST_NORMAL && tag_in_range && tag_code_active && !fault_cond
            && !short_dwell |=> safety_output_a && safety_output_b && led_yellow && !led_red;
    endproperty
    a_closed_on: assert property (p_closed_on) else $error("closed guard not shown");

    property p_open_off;
        st_reg == tisc_pkg::TISC_ST_NORMAL && !tag_in_range |-> ##1 (st_reg !=
            tisc_pkg::TISC_ST_NORMAL || (!safety_output_a && led_green && !led_yellow));
    endproperty
    a_open_off: assert property (p_open_off) else $error("open guard indication wrong");

    property p_teach_done;
        s_teach_end |=> st_reg == tisc_pkg::TISC_ST_TAUGHT && teach_commit
            ##1 !teach_commit && !led_green && !led_red && !safety_output_a;
    endproperty
    a_teach_done: assert property (p_teach_done) else $error("teach end wrong");

    property p_abort;
        st_reg == tisc_pkg::TISC_ST_TEACH && !tag_in_range && !fault_cond
            |=> st_reg == tisc_pkg::TISC_ST_OPERR && fl_reg == 2'd3 && led_red;
    endproperty
    a_abort: assert property (p_abort) else $error("early removal not rejected");

    property p_ninth;
        st_reg == tisc_pkg::TISC_ST_NORMAL && tag_in_range && !in_d_reg && !tag_code_active
            && !fault_cond && taught_count >= 4'd8 |=> fl_reg == 2'd1 && led_red;
    endproperty
    a_ninth: assert property (p_ninth) else $error("ninth teach accepted");

    property p_old;
        st_reg == tisc_pkg::TISC_ST_NORMAL && tag_in_range && !in_d_reg && !tag_code_active
            && tag_code_blocked && !fault_cond && taught_count < 4'd8
            |=> fl_reg == 2'd2 && led_red;
    endproperty
    a_old: assert property (p_old) else $error("old actuator accepted");

    property p_short;
        st_reg == tisc_pkg::TISC_ST_NORMAL && short_dwell
            |=> st_reg == tisc_pkg::TISC_ST_FAULT ##1 led_red && !led_green;
    endproperty
    a_short: assert property (p_short) else $error("short dwell not faulted");

    property p_latch;
        st_reg == tisc_pkg::TISC_ST_FAULT && !rejoin |=> st_reg == tisc_pkg::TISC_ST_FAULT
            && led_red && !safety_output_a && !safety_output_b;
    endproperty
    a_latch: assert property (p_latch) else $error("fault released early");

    property p_cond;
        fault_cond |-> ##[1:2] !safety_output_a && !safety_output_b;
    endproperty
    a_cond: assert property (p_cond) else $error("outputs on during fault");

endmodule

// ### tisc_regs.svh
// Timing constants and fixed figures for the teach-in and status controller.
// Assumes a single 100 MHz clock; all times are in milliseconds unless named otherwise.
`ifndef TISC_REGS_SVH
`define TISC_REGS_SVH

// ----------------------------------------------------------------------------
// Clock and tick
// ----------------------------------------------------------------------------
`define TISC_CLK_PERIOD_NS 10
`define TISC_TICK_US       1000
`define TISC_TICK_CYCLES   ((`TISC_TICK_US * 1000) / `TISC_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Times in milliseconds
// ----------------------------------------------------------------------------
`define TISC_TEACH_MS      16'd60000
`define TISC_CLEAR_MS      16'd2000
`define TISC_DWELL_MS      16'd500
`define TISC_FAST_HALF_MS  16'd125
`define TISC_FAST_PER_MS   16'd250
`define TISC_SLOW_HALF_MS  16'd500
`define TISC_SLOW_PER_MS   16'd1000

// ----------------------------------------------------------------------------
// Teach-in counts
// ----------------------------------------------------------------------------
`define TISC_TEACH_MAX     4'd8
`define TISC_FLASH_REPEAT  2'd1
`define TISC_FLASH_OLD     2'd2
`define TISC_FLASH_ABORT   2'd3

`endif

// ### tisc_pkg.sv
// Types shared by the teach-in and status controller.
// Assumes nothing of its surroundings.
package tisc_pkg;

    // ------------------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        TISC_ST_STATUS = 3'b000,
        TISC_ST_READY  = 3'b001,
        TISC_ST_NORMAL = 3'b010,
        TISC_ST_TEACH  = 3'b011,
        TISC_ST_TAUGHT = 3'b100,
        TISC_ST_OPERR  = 3'b101,
        TISC_ST_FAULT  = 3'b110
    } tisc_state_t;

endpackage

// ### tisc_actuator.sv
// Behavioural model of the actuator, its reader and the code store.
// Assumes the bench commands placement, code kind and faults at clock edges.
`timescale 1ns/1ps

module tisc_actuator (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Bench commands; kind 0 active, 1 new, 2 blocked
    input  wire logic       place,
    input  wire logic [1:0] kind,
    input  wire logic       fault,
    input  wire logic [3:0] count_set,
    input  wire logic       teach_commit,
    // Toward the controller
    output logic            tag_in_range,
    output logic            tag_code_active,
    output logic            tag_code_blocked,
    output logic [3:0]      taught_count,
    output logic            fault_cond
);
    // ------------------------------------------------------------------------
    // Code store
    // ------------------------------------------------------------------------
    logic [3:0] count_reg;
    logic [3:0] count_next;
    logic [3:0] line_reg;
    logic [3:0] line_next;

    // A count_set of 4'hf keeps the stored count across a restart.
    always_comb begin
        count_next = count_reg;
        if (rst && count_set != 4'hf) begin
            count_next = count_set;
        end else if (teach_commit && count_reg < 4'h8) begin
            count_next = count_reg + 4'h1;
        end
        line_next = {place, place && kind == 2'h0, place && kind == 2'h2, fault};
    end

    always_ff @(posedge clock) begin
        count_reg <= count_next;
        line_reg  <= line_next;
    end

    assign taught_count     = count_reg;
    assign tag_in_range     = line_reg[3];
    assign tag_code_active  = line_reg[2];
    assign tag_code_blocked = line_reg[1];
    assign fault_cond       = line_reg[0];
endmodule

// ### teach_in_status_controller_tb.sv
// Self-checking bench for the teach-in and status controller.
// Assumes the actuator model stands in for reader and store; tick is one cycle.
`timescale 1ns/1ps

module teach_in_status_controller_tb;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic       place = 1'b0;
    logic       fault = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [3:0] count_set = 4'h3;
    logic       tag_in_range, tag_code_active, tag_code_blocked, fault_cond, teach_commit;
    logic [3:0] taught_count;
    logic       safety_output_a, safety_output_b, led_green, led_yellow, led_red;
    int         err_total = 0;
    int         checked = 0;

    always #5 clock = ~clock;

    tisc_actuator partner (.clock, .rst, .place, .kind, .fault, .count_set, .teach_commit,
        .tag_in_range, .tag_code_active, .tag_code_blocked, .taught_count, .fault_cond);

    tisc_ctrl #(.TICK_CYCLES(1)) uut (.clock, .rst, .tag_in_range, .tag_code_active,
        .tag_code_blocked, .taught_count, .fault_cond, .teach_commit, .safety_output_a,
        .safety_output_b, .led_green, .led_yellow, .led_red);

    // ------------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------------
    function automatic bit differs(input logic [4:0] got, input logic [4:0] exp);
        checked++;
        return got !== exp;
    endfunction

    // Pattern is {output a, output b, green, yellow, red}.
    function automatic logic [4:0] outs();
        return {safety_output_a, safety_output_b, led_green, led_yellow, led_red};
    endfunction

    task automatic fail(input string msg);
        err_total++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic restart(input logic [3:0] c);
        count_set <= c;
        place     <= 1'b0;
        fault     <= 1'b0;
        rst       <= 1'b1;
        repeat (8) @(posedge clock);
        #1 if (differs(outs(), 5'h00)) fail("outputs live during reset");
        @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
    endtask

    // Counts green falling edges and notes any safety output that switched on.
    task automatic watch(input int n, output int falls, output logic any_on);
        logic prev;
        falls  = 0;
        any_on = 1'b0;
        prev   = led_green;
        repeat (n) begin
            @(posedge clock);
            #1;
            if (prev === 1'b1 && led_green === 1'b0) falls++;
            if (safety_output_a !== 1'b0 || safety_output_b !== 1'b0) any_on = 1'b1;
            prev = led_green;
        end
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_status(input logic [3:0] c, input int n);
        int   f;
        logic on;
        restart(c);
        watch(800, f, on);
        if (differs(f[4:0], n[4:0]) || on) fail("start-up flash count wrong");
        if (differs(outs(), 5'b00100)) fail("green not steady after count");
    endtask

    task automatic t_ready();
        int   f;
        logic on;
        restart(4'h0);
        watch(1000, f, on);
        checked++;
        if (f < 3 || f > 5 || on) fail("ready blink rate wrong");
        if (differs(outs() & 5'b11011, 5'h00)) fail("ready shows outputs or colour");
    endtask

    task automatic t_guard();
        int   f;
        logic on;
        restart(4'h3);
        watch(800, f, on);
        @(posedge clock);
        place <= 1'b1;
        repeat (600) @(posedge clock);
        #1 if (differs(outs(), 5'b11110)) fail("closed guard pattern wrong");
        @(posedge clock);
        place <= 1'b0;
        repeat (10) @(posedge clock);
        #1 if (differs(outs(), 5'b00100)) fail("open guard pattern wrong");
        @(posedge clock);
        place <= 1'b1;
        repeat (100) @(posedge clock);
        place <= 1'b0;
        repeat (10) @(posedge clock);
        #1 if (differs(outs(), 5'b00001)) fail("short dwell not a fault");
        repeat (2100) @(posedge clock);
        place <= 1'b1;
        repeat (2100) @(posedge clock);
        #1 if (differs(outs(), 5'b11110)) fail("fault not cleared by guard");
        @(posedge clock);
        place <= 1'b0;
    endtask

    task automatic t_fault();
        int   f;
        logic on;
        @(posedge clock);
        fault <= 1'b1;
        repeat (10) @(posedge clock);
        #1 if (differs(outs(), 5'b00001)) fail("internal fault not shown");
        @(posedge clock);
        fault <= 1'b0;
        repeat (100) @(posedge clock);
        #1 if (differs(outs(), 5'b00001)) fail("fault did not latch");
        @(posedge clock);
        fault <= 1'b1;
        repeat (2100) @(posedge clock);
        place <= 1'b1;
        repeat (2100) @(posedge clock);
        #1 if (differs(outs(), 5'b00001)) fail("held fault was cleared");
        restart(4'h7);
        watch(800, f, on);
        if (differs(f[4:0], 5'd1) || on) fail("restart did not clear fault");
    endtask

    task automatic t_err(input logic [3:0] c, input logic [1:0] k, input int hold, input int n);
        int   f;
        logic on;
        restart(c);
        watch(800, f, on);
        @(posedge clock);
        kind  <= k;
        place <= 1'b1;
        if (hold > 0) begin
            repeat (hold) @(posedge clock);
            place <= 1'b0;
        end
        watch(1000, f, on);
        if (differs(f[4:0], n[4:0]) || on) fail("error flash count wrong");
        if (differs(outs() & 5'b11011, 5'b00001)) fail("error not shown red");
    endtask

    task automatic t_teach();
        int   f;
        int   n;
        logic on;
        restart(4'h3);
        watch(800, f, on);
        @(posedge clock);
        kind  <= 2'h1;
        place <= 1'b1;
        watch(2000, f, on);
        if (differs(f[4:0], 5'd2) || on) fail("learning blink wrong");
        n = 0;
        while (teach_commit !== 1'b1 && n < 59000) begin
            @(posedge clock);
            #1;
            n++;
        end
        checked++;
        if (n < 57900 || n > 58100) fail("learning period wrong");
        if (differs(outs(), 5'h00)) fail("learned state not dark");
        restart(4'hf);
        watch(800, f, on);
        if (differs(f[4:0], 5'd3) || on) fail("new count not shown");
    endtask

    initial begin
        t_status(4'h3, 3);
        t_status(4'h6, 2);
        t_status(4'h7, 1);
        t_status(4'h8, 0);
        t_ready();
        t_guard();
        t_fault();
        t_err(4'h8, 2'h1, 0, 1);
        t_err(4'h3, 2'h2, 0, 2);
        t_err(4'h3, 2'h1, 1000, 3);
        t_teach();
        report_and_stop();
    end

    // The planned run is about 83000 cycles, so this only trips on a hang.
    initial begin
        repeat (99000) @(posedge clock);
        err_total++;
        report_and_stop();
    end
endmodule
